// ===== rtl/ecw_pkg.sv
/*
  Constants, types and helpers shared by the configuration image loader.
  Assumes a 16-bit device address map and an 8-bit data path.
*/
package ecw_pkg;
  // Image regions copied between device and serial memory
  localparam logic [15:0] TXS_BASE = 16'h4000;
  localparam logic [15:0] TXS_LAST = 16'h5fff;
  localparam logic [15:0] LUT_BASE = 16'h7a00;
  localparam logic [15:0] LUT_LAST = 16'h7bff;
  localparam logic [15:0] CFG_BASE = 16'h8000;
  localparam logic [15:0] CFG_LAST_DEF = 16'h80ff;
  localparam logic [15:0] CKSUM_ADDR = 16'hffff;
  // Arming sequence
  localparam logic [15:0] ARM_ADDR = 16'h8fff;
  localparam logic [7:0] ARM_KEY1 = 8'h5a;
  localparam logic [7:0] ARM_KEY2 = 8'ha5;
  // Serial memory instructions and frame lengths in bits
  localparam logic [7:0] SPI_WREN = 8'h06;
  localparam logic [7:0] SPI_WRITE = 8'h02;
  localparam logic [7:0] SPI_READ = 8'h03;
  localparam logic [7:0] SPI_RDSR = 8'h05;
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_STAT = 6'h10;
  localparam logic [5:0] LEN_XFER = 6'h20;
  localparam int WIP_BIT = 0;
  // Timing
  localparam int CLK_NS = 40;
  localparam int COPY_OUT_TRIGGER_IN_MIN_NS = 1000000;
  localparam int BOOT_WAIT = 2;
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_COPY_OUT_TRIGGER_IN_EN = 1;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam int STS_LOAD_DONE = 0;
  localparam int STS_LOAD_ERR = 1;
  localparam int STS_COPY_OUT_TRIGGER_IN_DONE = 2;
  localparam int STS_VFY_ERR = 3;
  localparam logic [3:0] MASK_RST = 4'ha;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h0, ST_IDLE = 4'h1, ST_MEM_RD = 4'h2, ST_MEM_WT = 4'h3,
    ST_SPI_GO = 4'h4, ST_SPI_WT = 4'h5, ST_MEM_WR = 4'h6, ST_NEXT = 4'h7,
    ST_SAFE = 4'h8
  } ecw_state_e;
  typedef enum logic [1:0] {
    PH_LOAD = 2'h0, PH_COPY_OUT_TRIGGER_IN = 2'h1, PH_VFY = 2'h2
  } ecw_phase_e;
  typedef enum logic [1:0] {
    SO_READ = 2'h0, SO_WREN = 2'h1, SO_WRITE = 2'h2, SO_POLL = 2'h3
  } ecw_op_e;

  function automatic logic [15:0] ecw_next_addr(input logic [15:0] a);
    if (a == TXS_LAST) return LUT_BASE;
    if (a == LUT_LAST) return CFG_BASE;
    return a + 16'h0001;
  endfunction : ecw_next_addr

  function automatic logic ecw_in_image(input logic [15:0] a,
                                        input logic [15:0] last);
    return (a >= TXS_BASE && a <= TXS_LAST) ||
           (a >= LUT_BASE && a <= LUT_LAST) ||
           (a >= CFG_BASE && a <= last);
  endfunction : ecw_in_image
endpackage : ecw_pkg

// ===== rtl/ecw_loader.sv
/*
  Configuration image loader and write-back engine: loads the device
  memory from a serial memory after reset, and on an armed trigger copies
  the image back, writes its checksum and verifies it byte by byte.
  Assumes a single-cycle internal memory port (read data one cycle after
  the strobe) and a mode 0 serial memory with a status busy bit.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
// Overview of operation
// - After reset, load the whole configuration from a 64 KB serial memory.
// - Every configuration block moves in both load and programming.
// - Received data area and receive queues never move either way.
// - Image mirrors device map; configuration registers from 0x8000 up.
// - Look-up tables sit at 0x7A00 to 0x7BFF in both.
// - Four schedule tables fill 2 KB slots from 0x4000 to 0x5FFF.
// - Other host activity between steps or a short pulse cancels start.
// - Trigger falling edge starts the cycle, drops ready, copies image.
// - After copying, compare every serial memory byte with device data.
// - A clean verification raises ready again.
// - Also store the two's complement of the image checksum.
// - Mismatch: enter safe state, set verify error, raise interrupt.
`timescale 1ns/1ns
module ecw_loader import ecw_pkg::*; #(
  parameter int PULSE_MIN_CYC = (COPY_OUT_TRIGGER_IN_MIN_NS + CLK_NS - 1) / CLK_NS,
  parameter int SCK_HALF = 4,
  parameter logic [15:0] CFG_LAST = CFG_LAST_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic operate_select_in,
  input wire logic autoinit_en_in,
  input wire logic copy_out_trigger_in,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic ready,
  output logic safe_state,
  output logic irq
);
  if (PULSE_MIN_CYC < 1 || PULSE_MIN_CYC > 65535) begin : g_bad_pulse
    $error("PULSE_MIN_CYC out of range");
  end
  if (SCK_HALF < 3 || SCK_HALF > 255) begin : g_bad_sck
    $error("SCK_HALF must leave room for the input synchroniser");
  end
  if (CFG_LAST < CFG_BASE || CFG_LAST >= ARM_ADDR) begin : g_bad_cfg
    $error("CFG_LAST outside the register window");
  end

  logic [1:0] run_q, trig_q, miso_q, boot_q;
  logic trig_d_r;
  logic [15:0] pw_cnt_r;
  logic [1:0] arm_r;
  logic [1:0] boot_cnt_r;
  ecw_state_e st_r;
  ecw_phase_e ph_r;
  ecw_op_e op_r;
  logic [15:0] addr_r;
  logic [7:0] data_r, sum_r, ck_val_r;
  logic ck_r;
  logic go_r;
  logic [31:0] tx_r;
  logic [5:0] len_r;
  logic busy_r, done_r;
  logic [31:0] sh_r;
  logic [5:0] cnt_r;
  logic [7:0] div_r, rx_r;
  logic [7:0] ctrl_r;
  logic [3:0] sts_r, mask_r;
  logic reload_r;
  logic trig_fall, start_go, rd_done, tick;
  logic [3:0] ev;

  // Pins from outside the clock domain pass two flip-flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 2'h0;
      trig_q <= 2'h0;
      miso_q <= 2'h0;
      boot_q <= 2'h0;
      trig_d_r <= 1'b0;
    end else begin
      run_q <= {run_q[0], operate_select_in};
      trig_q <= {trig_q[0], copy_out_trigger_in};
      miso_q <= {miso_q[0], spi_miso};
      boot_q <= {boot_q[0], autoinit_en_in};
      trig_d_r <= trig_q[1];
    end
  end

  assign trig_fall = trig_d_r && !trig_q[1];

  // Width counter saturates so an over-long pulse still qualifies
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_cnt_r <= 16'h0000;
    end else if (trig_q[1]) begin
      if (pw_cnt_r != 16'hffff) begin
        pw_cnt_r <= pw_cnt_r + 16'h0001;
      end
    end else begin
      pw_cnt_r <= 16'h0000;
    end
  end

  assign start_go = trig_fall && arm_r == 2'h2 && !run_q[1] &&
                    pw_cnt_r >= 16'(PULSE_MIN_CYC) &&
                    st_r == ST_IDLE && ctrl_r[CTRL_COPY_OUT_TRIGGER_IN_EN];

  // Any host access that is not the expected key write drops the arming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_r <= 2'h0;
    end else if (st_r != ST_IDLE || trig_fall) begin
      arm_r <= 2'h0;
    end else if (host_wr || host_rd) begin
      if (arm_r == 2'h1 && host_wr && host_addr == ARM_ADDR &&
          host_wdata == ARM_KEY2) begin
        arm_r <= 2'h2;
      end else if (host_wr && host_addr == ARM_ADDR &&
                   host_wdata == ARM_KEY1) begin
        arm_r <= 2'h1;
      end else begin
        arm_r <= 2'h0;
      end
    end
  end

  // Serial master, mode 0; the clock is a divided enable, not a domain
  assign tick = busy_r && div_r == 8'(SCK_HALF - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      div_r <= 8'h00;
      sh_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      rx_r <= 8'h00;
      spi_sck <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
    end else begin
      done_r <= 1'b0;
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (go_r) begin
        busy_r <= 1'b1;
        div_r <= 8'h00;
        spi_cs_n <= 1'b0;
        spi_mosi <= tx_r[31];
        sh_r <= {tx_r[30:0], 1'b0};
        cnt_r <= len_r;
      end else if (tick && !spi_sck) begin
        spi_sck <= 1'b1;
        rx_r <= {rx_r[6:0], miso_q[1]};
        cnt_r <= cnt_r - 6'h01;
      end else if (tick) begin
        spi_sck <= 1'b0;
        if (cnt_r == 6'h00) begin
          spi_cs_n <= 1'b1;
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          spi_mosi <= sh_r[31];
          sh_r <= {sh_r[30:0], 1'b0};
        end
      end
    end
  end

  assign rd_done = st_r == ST_SPI_WT && done_r && op_r == SO_READ;

  always_comb begin
    ev = 4'h0;
    ev[STS_VFY_ERR] = rd_done && ph_r == PH_VFY && rx_r != data_r;
    ev[STS_LOAD_ERR] = rd_done && ph_r == PH_LOAD && ck_r &&
                       sum_r + rx_r != 8'h00;
    ev[STS_LOAD_DONE] = rd_done && ph_r == PH_LOAD && ck_r &&
                        sum_r + rx_r == 8'h00;
    ev[STS_COPY_OUT_TRIGGER_IN_DONE] = st_r == ST_NEXT && ck_r && ph_r == PH_VFY;
  end

  // Sequencer: one byte at a time through the image regions only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_BOOT;
      ph_r <= PH_LOAD;
      op_r <= SO_READ;
      addr_r <= TXS_BASE;
      data_r <= 8'h00;
      sum_r <= 8'h00;
      ck_val_r <= 8'h00;
      ck_r <= 1'b0;
      go_r <= 1'b0;
      tx_r <= 32'h0000_0000;
      len_r <= LEN_CMD;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      boot_cnt_r <= 2'h0;
    end else begin
      go_r <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (st_r)
        ST_BOOT, ST_IDLE: begin
          if (st_r == ST_BOOT && boot_cnt_r != 2'(BOOT_WAIT)) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
          end else if ((st_r == ST_BOOT && boot_q[1]) || reload_r) begin
            ph_r <= PH_LOAD;
            addr_r <= TXS_BASE;
            sum_r <= 8'h00;
            ck_r <= 1'b0;
            op_r <= SO_READ;
            st_r <= ST_SPI_GO;
          end else if (start_go) begin
            ph_r <= PH_COPY_OUT_TRIGGER_IN;
            addr_r <= TXS_BASE;
            sum_r <= 8'h00;
            ck_r <= 1'b0;
            st_r <= ST_MEM_RD;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_MEM_RD: begin
          mem_rd <= 1'b1;
          st_r <= ST_MEM_WT;
        end
        ST_MEM_WT: begin
          if (!mem_rd) begin
            data_r <= mem_rdata;
            if (ph_r == PH_COPY_OUT_TRIGGER_IN) begin
              sum_r <= sum_r + mem_rdata;
              op_r <= SO_WREN;
            end else begin
              op_r <= SO_READ;
            end
            st_r <= ST_SPI_GO;
          end
        end
        ST_SPI_GO: begin
          go_r <= 1'b1;
          case (op_r)
            SO_WREN: begin
              tx_r <= {SPI_WREN, 24'h000000};
              len_r <= LEN_CMD;
            end
            SO_WRITE: begin
              tx_r <= {SPI_WRITE, addr_r, data_r};
              len_r <= LEN_XFER;
            end
            SO_POLL: begin
              tx_r <= {SPI_RDSR, 24'h000000};
              len_r <= LEN_STAT;
            end
            default: begin
              tx_r <= {SPI_READ, addr_r, 8'h00};
              len_r <= LEN_XFER;
            end
          endcase
          st_r <= ST_SPI_WT;
        end
        ST_SPI_WT: begin
          if (done_r) begin
            case (op_r)
              SO_WREN: begin
                op_r <= SO_WRITE;
                st_r <= ST_SPI_GO;
              end
              SO_WRITE: begin
                op_r <= SO_POLL;
                st_r <= ST_SPI_GO;
              end
              SO_POLL: begin
                st_r <= rx_r[WIP_BIT] ? ST_SPI_GO : ST_NEXT;
              end
              default: begin
                if (ev[STS_VFY_ERR] || ev[STS_LOAD_ERR]) begin
                  st_r <= ST_SAFE;
                end else if (ev[STS_LOAD_DONE]) begin
                  st_r <= ST_IDLE;
                end else if (ph_r == PH_LOAD) begin
                  data_r <= rx_r;
                  sum_r <= sum_r + rx_r;
                  st_r <= ST_MEM_WR;
                end else begin
                  st_r <= ST_NEXT;
                end
              end
            endcase
          end
        end
        ST_MEM_WR: begin
          mem_wr <= 1'b1;
          mem_wdata <= data_r;
          st_r <= ST_NEXT;
        end
        ST_NEXT: begin
          if (ck_r && ph_r == PH_COPY_OUT_TRIGGER_IN) begin
            ph_r <= PH_VFY;
            addr_r <= TXS_BASE;
            ck_r <= 1'b0;
            st_r <= ST_MEM_RD;
          end else if (ck_r) begin
            st_r <= ST_IDLE;
          end else if (addr_r == CFG_LAST) begin
            ck_r <= 1'b1;
            addr_r <= CKSUM_ADDR;
            st_r <= ST_SPI_GO;
            if (ph_r == PH_COPY_OUT_TRIGGER_IN) begin
              data_r <= 8'h00 - sum_r;
              ck_val_r <= 8'h00 - sum_r;
              op_r <= SO_WREN;
            end else begin
              data_r <= ck_val_r;
              op_r <= SO_READ;
            end
          end else begin
            addr_r <= ecw_next_addr(addr_r);
            op_r <= SO_READ;
            st_r <= ph_r == PH_LOAD ? ST_SPI_GO : ST_MEM_RD;
          end
        end
        ST_SAFE: begin
          if (!sts_r[STS_VFY_ERR] && !sts_r[STS_LOAD_ERR]) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign mem_addr = addr_r;

  // Register port; status is write-one-to-clear and a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      sts_r <= 4'h0;
      reload_r <= 1'b0;
    end else begin
      reload_r <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RELOAD];
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_r <= reg_wdata & CTRL_RST;
      end
      if (reg_wr && reg_addr == REG_MASK) begin
        mask_r <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == REG_STS) begin
        sts_r <= (sts_r & ~reg_wdata[3:0]) | ev;
      end else begin
        sts_r <= sts_r | ev;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= ctrl_r;
        REG_STS: reg_rdata <= {4'h0, sts_r};
        REG_MASK: reg_rdata <= {4'h0, mask_r};
        REG_STATE: reg_rdata <= {1'b0, ready, arm_r, st_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
      safe_state <= 1'b0;
      irq <= 1'b0;
    end else begin
      ready <= st_r == ST_IDLE;
      safe_state <= st_r == ST_SAFE;
      irq <= |(sts_r & mask_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  arm_before_go_a: assert property (
      st_r == ST_MEM_RD && $past(st_r) == ST_IDLE
      |-> $past(arm_r) == 2'h2 && !$past(run_q[1]) &&
      $past(pw_cnt_r) >= 16'(PULSE_MIN_CYC))
    else $error("Programming started without arming or while running");
  pulse_width_a: assert property (trig_fall && pw_cnt_r < 16'(PULSE_MIN_CYC)
      |=> st_r == ST_IDLE || st_r == ST_BOOT)
    else $error("Short trigger pulse started a cycle");
  ready_drop_a: assert property (start_go |=> ##1 (!ready)[*3])
    else $error("Ready stayed high after programming start");
  image_only_a: assert property (mem_rd || mem_wr
      |-> ecw_in_image(mem_addr, CFG_LAST))
    else $error("Access outside the configuration image");
  verify_ready_a: assert property (ev[STS_COPY_OUT_TRIGGER_IN_DONE]
      |-> ##2 ready && !safe_state)
    else $error("Ready did not rise after clean verification");
  cksum_value_a: assert property (go_r && op_r == SO_WRITE && ck_r
      |-> sum_r + tx_r[7:0] == 8'h00 && tx_r[23:8] == CKSUM_ADDR)
    else $error("Checksum byte is not the two's complement");
  mismatch_safe_a: assert property (ev[STS_VFY_ERR]
      |=> st_r == ST_SAFE && sts_r[STS_VFY_ERR])
    else $error("Mismatch did not enter safe state");
  error_irq_a: assert property (ev[STS_VFY_ERR] && mask_r[STS_VFY_ERR]
      |-> ##2 irq && safe_state)
    else $error("Interrupt missing after verify error");
  safe_hold_a: assert property (st_r == ST_SAFE && sts_r[STS_VFY_ERR]
      |=> st_r == ST_SAFE)
    else $error("Left safe state with error still set");
  verify_order_a: assert property (ph_r == PH_VFY && mem_rd
      |-> $past(ph_r, 1) == PH_VFY || $past(ph_r, 1) == PH_COPY_OUT_TRIGGER_IN)
    else $error("Verification entered from wrong phase");
endmodule : ecw_loader

// ===== tb/ecw_eeprom_model.sv
/*
  Behavioural serial configuration memory, mode 0, MSB first.
  Assumes the master idles sck low and frames each command with cs_n.
*/
`timescale 1ns/1ns
module ecw_eeprom_model #(
  parameter int BUSY_POLLS = 2
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output int n_wr,
  output int n_bad
);
  logic [7:0] mem [0:65535];
  logic [31:0] sh;
  logic [7:0] out_r;
  logic outing;
  logic wel;
  int cnt;
  int busy;
  localparam logic [7:0] SPI_WREN_M = 8'h06;

  initial begin
    miso = 1'b0;
    n_wr = 0;
    n_bad = 0;
    busy = 0;
    wel = 1'b0;
    outing = 1'b0;
  end

  always @(negedge cs_n) begin
    cnt = 0;
    outing = 1'b0;
  end

  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[30:0], mosi};
      cnt++;
      if (cnt == 8 && sh[7:0] == SPI_WREN_M) wel = 1'b1;
      if (cnt == 8 && sh[7:0] == 8'h05) begin
        out_r = {7'h00, busy != 0};
        outing = 1'b1;
        if (busy > 0) busy--;
      end
      if (cnt == 24 && sh[23:16] == 8'h03) begin
        out_r = mem[sh[15:0]];
        outing = 1'b1;
      end
      // A write without enable or while busy is lost, as on the real part
      if (cnt == 32 && sh[31:24] == 8'h02) begin
        if (!wel || busy != 0) n_bad++;
        else begin
          mem[sh[23:8]] = sh[7:0];
          n_wr++;
        end
        busy = BUSY_POLLS;
        wel = 1'b0;
      end
    end
  end

  // Released or idle line shows the inverse, never the last bit
  always @(negedge sck or posedge cs_n) begin
    if (!cs_n && outing) begin
      miso = out_r[7];
      out_r = out_r << 1;
    end else begin
      miso = ~miso;
    end
  end
endmodule : ecw_eeprom_model

// ===== tb/tb_ecw_loader.sv
/*
  Self-checking bench for the configuration image loader.
  Assumes the serial memory model and a 25 MHz clock; a full image copy
  takes millions of cycles, so only the start of a copy is followed.
*/
`timescale 1ns/1ns
module tb_ecw_loader;
  import ecw_pkg::*;
  localparam int PMIN = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0] host_wdata = 8'h00;
  logic op_sel = 1'b0;
  logic trig = 1'b0;
  logic boot_en = 1'b0;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata = 8'h00;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic ready;
  logic safe_state;
  logic irq;
  int n_wr;
  int n_bad;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;

  always #20 clk = ~clk;

  ecw_loader #(.PULSE_MIN_CYC(PMIN), .SCK_HALF(4), .CFG_LAST(16'h8003)) uut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .operate_select_in(op_sel),
    .autoinit_en_in(boot_en), .copy_out_trigger_in(trig),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .ready(ready),
    .safe_state(safe_state), .irq(irq)
  );

  ecw_eeprom_model #(.BUSY_POLLS(2)) eeprom (
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .n_wr(n_wr), .n_bad(n_bad)
  );

  // Internal memory: data one cycle after the strobe, a fixed pattern
  always @(posedge clk) begin
    if (mem_rd) mem_rdata <= mem_addr[7:0] ^ 8'h3c;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk1(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp({8'h00, reg_rdata}, {8'h00, exp});
  endtask : reg_read

  task automatic host(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    host_wr <= w;
    host_rd <= !w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
  endtask : host

  task automatic arm();
    host(1'b1, ARM_ADDR, ARM_KEY1);
    host(1'b1, ARM_ADDR, ARM_KEY2);
  endtask : arm

  // High for n edges, then room for the synchronised fall to land
  task automatic pulse(input int n);
    @(posedge clk);
    trig <= 1'b1;
    repeat (n) @(posedge clk);
    trig <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse

  // First internal write of a load: image byte 0 as programmed below
  task automatic wait_mem_wr();
    int n;
    n = 0;
    while (mem_wr !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(mem_wr, 1'b1);
    cmp(mem_addr, TXS_BASE);
    cmp({8'h00, mem_wdata}, {8'h00, 8'h3c});
  endtask : wait_mem_wr

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    reg_read(REG_CTRL, CTRL_RST);
    reg_read(REG_MASK, {4'h0, MASK_RST});
    reg_read(REG_STS, 8'h00);
    reg_read(REG_STATE, 8'h41);
    reg_write(4'h9, 8'hff);
    reg_read(4'h9, 8'h00);
    reg_write(REG_MASK, 8'h0f);
    reg_read(REG_MASK, 8'h0f);
    reg_write(REG_STS, 8'h0f);
    reg_read(REG_STS, 8'h00);
    chk1(irq, 1'b0);
    host(1'b1, ARM_ADDR, ARM_KEY1);
    reg_read(REG_STATE, 8'h51);
    host(1'b1, ARM_ADDR, ARM_KEY2);
    reg_read(REG_STATE, 8'h61);
    host(1'b0, ARM_ADDR, 8'h00);
    reg_read(REG_STATE, 8'h41);
    host(1'b1, ARM_ADDR, ARM_KEY1);
    host(1'b1, CFG_BASE, ARM_KEY2);
    reg_read(REG_STATE, 8'h41);
    // Activity between the second key and the pulse cancels the start
    arm();
    host(1'b0, TXS_BASE, 8'h00);
    pulse(PMIN + 4);
    chk1(ready, 1'b1);
    reg_read(REG_STATE, 8'h41);
    // One cycle short of the minimum width
    arm();
    pulse(PMIN - 1);
    chk1(ready, 1'b1);
    reg_read(REG_STATE, 8'h41);
    @(posedge clk);
    op_sel <= 1'b1;
    repeat (4) @(posedge clk);
    arm();
    pulse(PMIN + 4);
    chk1(ready, 1'b1);
    reg_read(REG_STATE, 8'h41);
    @(posedge clk);
    op_sel <= 1'b0;
    repeat (4) @(posedge clk);
    // Exactly the minimum width starts the copy on the fall
    arm();
    @(posedge clk);
    trig <= 1'b1;
    repeat (PMIN) @(posedge clk);
    trig <= 1'b0;
    #1;
    chk1(ready, 1'b1);
    k = 0;
    while (mem_rd !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1(mem_rd, 1'b1);
    cmp(mem_addr, TXS_BASE);
    repeat (4) @(posedge clk);
    chk1(ready, 1'b0);
    k = 0;
    while (n_wr < 3 && k < 8000) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < 3; i++) begin
      cmp({8'h00, eeprom.mem[TXS_BASE + 16'(i)]},
          {8'h00, 8'(i) ^ 8'h3c});
    end
    cmp(16'(n_bad), 16'h0000);
    chk1(ready, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    chk1(ready, 1'b0);
    chk1(cs_n, 1'b1);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk1(ready, 1'b1);
    reg_read(REG_STATE, 8'h41);
    // Reload from the image just written; bit 1 keeps programming enabled
    reg_write(REG_CTRL, 8'h03);
    wait_mem_wr();
    chk1(ready, 1'b0);
    chk1(safe_state, 1'b0);
    // Strap high across a reset: the load starts on its own
    @(posedge clk);
    boot_en <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_mem_wr();
    chk1(ready, 1'b0);
    end_sim();
  end
endmodule : tb_ecw_loader
